// [rtl/selfgain_threshold_regs.sv]
// self-gain registers, channel-0 lower limit and serial register port
`timescale 1ns/1ps
module selfgain_threshold_regs
   import selfgain_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        spi_sclk,
   input  wire logic        spi_cs_n,
   input  wire logic        spi_mosi,
   output logic             spi_miso,
   output logic             spi_miso_oe,
   input  wire logic [2:0]  pga_gain_sel,
   input  wire logic [23:0] low_gain_scale,
   input  wire logic        corr_valid,
   input  wire logic [23:0] corr_result,
   output logic             scaled_valid,
   output logic      [23:0] scaled_result,
   input  wire logic        cal_wr_valid,
   input  wire logic [2:0]  cal_wr_gain_sel,
   input  wire logic [23:0] cal_wr_value,
   input  wire logic        ch0_result_valid,
   input  wire logic [23:0] ch0_conversion_result,
   input  wire logic        unipolar_bipolar_select,
   input  wire logic        format_offset_binary,
   output logic             ch0_under_range_flag
);
   typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA} frame_state_t;

   logic [2:0]         pins_sync;
   logic               sclk_s;
   logic               cs_n_s;
   logic               mosi_s;
   logic               sclk_prev_reg;
   logic               sclk_rise;
   logic               sclk_fall;

   frame_state_t       state_reg;
   frame_state_t       state_next;
   logic [CNT_W-1:0]   cnt_reg;
   logic [CNT_W-1:0]   cnt_next;
   logic [31:0]        rx_reg;
   logic [31:0]        rx_next;
   logic [23:0]        tx_reg;
   logic [23:0]        tx_next;
   logic               is_read_reg;
   logic               is_read_next;
   logic [ADDR_W-1:0]  addr_reg;
   logic [ADDR_W-1:0]  addr_next;
   logic               host_wr;
   logic [23:0]        rd_data;

   logic [23:0]        gain_reg [NUM_GAIN_REGS];
   logic [23:0]        gain_next [NUM_GAIN_REGS];
   logic [23:0]        limit_reg;
   logic [23:0]        limit_next;
   logic               under_reg;
   logic               under_next;
   logic               below;
   logic [23:0]        scale_sel;

   // ----------------------------------------
   // pin synchronisation
   // ----------------------------------------
   pin_sync #(
      .WIDTH (3),
      .INIT  (3'b010)
   ) u_pin_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .pin_in   ({spi_sclk, spi_cs_n, spi_mosi}),
      .sync_out (pins_sync)
   );

   assign sclk_s    = pins_sync[2];
   assign cs_n_s    = pins_sync[1];
   assign mosi_s    = pins_sync[0];
   assign sclk_rise = sclk_s && !sclk_prev_reg;
   assign sclk_fall = !sclk_s && sclk_prev_reg;

   // ----------------------------------------
   // serial frame: command byte then 24 data bits
   // ----------------------------------------
   // four bytes msb first
   always_comb begin
      state_next   = state_reg;
      cnt_next     = cnt_reg;
      rx_next      = rx_reg;
      tx_next      = tx_reg;
      is_read_next = is_read_reg;
      addr_next    = addr_reg;
      host_wr      = 1'b0;
      if (cs_n_s) begin
         // deselect abandons a partial frame; nothing is written
         state_next = ST_IDLE;
         cnt_next   = '0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               state_next = ST_CMD;
               cnt_next   = '0;
            end
            ST_CMD: begin
               if (sclk_rise) begin
                  rx_next  = {rx_reg[30:0], mosi_s};
                  cnt_next = cnt_reg + 6'd1;
                  if (cnt_reg == 6'(CMD_BITS - 1)) begin
                     is_read_next = rx_next[CMD_READ_BIT];
                     addr_next    = rx_next[ADDR_W-1:0];
                     state_next   = ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               if (sclk_rise && cnt_reg < 6'(FRAME_BITS)) begin
                  rx_next  = {rx_reg[30:0], mosi_s};
                  cnt_next = cnt_reg + 6'd1;
                  if (cnt_reg == 6'(FRAME_BITS - 1)) begin
                     host_wr = !is_read_reg;
                  end
               end
               // first data bit already sits on the pin after the load
               if (sclk_fall && cnt_reg > 6'(CMD_BITS)) begin
                  tx_next = {tx_reg[22:0], 1'b0};
               end
            end
         endcase
      end
      if (state_reg == ST_CMD && state_next == ST_DATA) begin
         tx_next = rd_data;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_reg     <= ST_IDLE;
         cnt_reg       <= '0;
         rx_reg        <= '0;
         tx_reg        <= '0;
         is_read_reg   <= 1'b0;
         addr_reg      <= '0;
         sclk_prev_reg <= 1'b0;
      end else begin
         state_reg     <= state_next;
         cnt_reg       <= cnt_next;
         rx_reg        <= rx_next;
         tx_reg        <= tx_next;
         is_read_reg   <= is_read_next;
         addr_reg      <= addr_next;
         sclk_prev_reg <= sclk_s;
      end
   end

   assign spi_miso    = tx_reg[23];
   assign spi_miso_oe = !cs_n_s;

   // ----------------------------------------
   // read mux; unmapped addresses read zero
   // ----------------------------------------
   always_comb begin
      rd_data = 24'h000000;
      if (addr_next >= ADDR_GAIN8 && addr_next <= ADDR_GAIN128) begin
         rd_data = gain_reg[3'(addr_next - ADDR_GAIN8)];
      end else if (addr_next == ADDR_LIMIT0) begin
         rd_data = limit_reg;
      end
   end

   // ----------------------------------------
   // gain words and lower limit
   // ----------------------------------------
   // hold until write
   always_comb begin
      for (int i = 0; i < NUM_GAIN_REGS; i++) begin
         gain_next[i] = gain_reg[i];
         // host word update
         // last data bit lands this cycle, so take the shifter's next value
         if (host_wr && addr_reg == ADDR_GAIN8 + 7'(i)) begin
            gain_next[i] = rx_next[23:0];
         end
         // a calibration run finishing last is the fresher value
         if (cal_wr_valid && cal_wr_gain_sel == GAIN_SEL_8 + 3'(i)) begin
            gain_next[i] = cal_wr_value;
         end
      end
      limit_next = limit_reg;
      if (host_wr && addr_reg == ADDR_LIMIT0) begin
         limit_next = rx_next[23:0];
      end
   end

   // ----------------------------------------
   // channel-0 lower-limit comparison
   // ----------------------------------------
   // coding-aware compare
   always_comb begin
      if (!unipolar_bipolar_select && !format_offset_binary) begin
         below = $signed(ch0_conversion_result) < $signed(limit_reg);
      end else begin
         below = ch0_conversion_result < limit_reg;
      end
      under_next = under_reg;
      if (ch0_result_valid) begin
         under_next = below;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_GAIN_REGS; i++) begin
            gain_reg[i] <= GAIN_RESET;
         end
         limit_reg <= LIMIT_RESET;
         under_reg <= 1'b0;
      end else begin
         gain_reg  <= gain_next;
         limit_reg <= limit_next;
         under_reg <= under_next;
      end
   end

   assign ch0_under_range_flag = under_reg;

   // ----------------------------------------
   // self-gain scaling path
   // ----------------------------------------
   // word of the active gain
   always_comb begin
      scale_sel = low_gain_scale;
      if (pga_gain_sel >= GAIN_SEL_8) begin
         scale_sel = gain_reg[3'(pga_gain_sel - GAIN_SEL_8)];
      end
   end

   gain_scaler u_gain_scaler (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_valid  (corr_valid),
      .in_data   (corr_result),
      .scale     (scale_sel),
      .out_valid (scaled_valid),
      .out_data  (scaled_result)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_write_commit;
      host_wr && !cal_wr_valid;
   endsequence

   a_gain8_write: assert property (
      s_write_commit ##0 addr_reg == ADDR_GAIN8 |=> gain_reg[0] == rx_reg[23:0])
      else $error("gain-8 word missed a host write");
   a_gain16_write: assert property (
      s_write_commit ##0 addr_reg == ADDR_GAIN16 |=> gain_reg[1] == rx_reg[23:0])
      else $error("gain-16 word missed a host write");
   a_gain32_write: assert property (
      s_write_commit ##0 addr_reg == ADDR_GAIN32 |=> gain_reg[2] == rx_reg[23:0])
      else $error("gain-32 word missed a host write");
   a_gain64_write: assert property (
      s_write_commit ##0 addr_reg == ADDR_GAIN64 |=> gain_reg[3] == rx_reg[23:0])
      else $error("gain-64 word missed a host write");
   a_gain128_write: assert property (
      s_write_commit ##0 addr_reg == ADDR_GAIN128 |=> gain_reg[4] == rx_reg[23:0])
      else $error("gain-128 word missed a host write");
   a_gain_hold: assert property (
      !host_wr && !cal_wr_valid |=> $stable(gain_reg[2]) && $stable(limit_reg))
      else $error("stored word changed without a write");
   a_cal_overwrite: assert property (
      cal_wr_valid && cal_wr_gain_sel == GAIN_SEL_128 |=> gain_reg[4] == $past(cal_wr_value))
      else $error("calibration value not stored");
   a_limit_write: assert property (
      host_wr && addr_reg == ADDR_LIMIT0 |=> limit_reg == rx_reg[23:0])
      else $error("limit word missed a host write");
   a_under_set: assert property (
      ch0_result_valid && below |=> ch0_under_range_flag ##1 
      (ch0_under_range_flag || $past(ch0_result_valid)))
      else $error("under-range flag not raised");
   a_under_clear: assert property (
      ch0_result_valid && !below |=> !ch0_under_range_flag)
      else $error("under-range flag raised without cause");
   a_flag_hold: assert property (
      !ch0_result_valid |=> $stable(ch0_under_range_flag))
      else $error("under-range flag moved without a new result");
   a_signed_compare: assert property (
      ch0_result_valid && !unipolar_bipolar_select && !format_offset_binary
      && ch0_conversion_result[23] && !limit_reg[23] |=> ch0_under_range_flag)
      else $error("two's complement compare treated as unsigned");
   a_scale_select: assert property (
      pga_gain_sel == GAIN_SEL_8 |-> scale_sel == gain_reg[0])
      else $error("wrong correction word for active gain");
   a_scale_select_top: assert property (
      pga_gain_sel == GAIN_SEL_128 |-> scale_sel == gain_reg[4])
      else $error("wrong correction word for top gain");
   a_read_load: assert property (
      state_reg == ST_CMD && state_next == ST_DATA |=> spi_miso == tx_reg[23]
      ##0 tx_reg == $past(rd_data))
      else $error("read word not loaded msb first");
endmodule : selfgain_threshold_regs

// [rtl/selfgain_pkg.sv]
// constants for the self-gain and channel-0 lower-limit register bank
package selfgain_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam int        ADDR_W         = 7;
   localparam int        DATA_W         = 24;
   localparam logic [6:0] ADDR_GAIN8    = 7'h1b;
   localparam logic [6:0] ADDR_GAIN16   = 7'h1c;
   localparam logic [6:0] ADDR_GAIN32   = 7'h1d;
   localparam logic [6:0] ADDR_GAIN64   = 7'h1e;
   localparam logic [6:0] ADDR_GAIN128  = 7'h1f;
   localparam logic [6:0] ADDR_LIMIT0   = 7'h20;
   localparam int        NUM_GAIN_REGS  = 5;
   // reset values are not documented; unity scale and zero limit
   localparam logic [23:0] GAIN_RESET   = 24'h800000;
   localparam logic [23:0] LIMIT_RESET  = 24'h000000;
   localparam logic [23:0] SCALE_UNITY  = 24'h800000;
   // ----------------------------------------
   // amplifier gain codes (1,2,4,8..128)
   // ----------------------------------------
   localparam logic [2:0] GAIN_SEL_8    = 3'h3;
   localparam logic [2:0] GAIN_SEL_128  = 3'h7;
   localparam int        FRAC_BITS      = 23;
   // ----------------------------------------
   // serial frame layout
   // ----------------------------------------
   localparam int        CMD_BITS       = 8;
   localparam int        FRAME_BITS     = 32;
   localparam int        CMD_READ_BIT   = 7;
   localparam int        CNT_W          = 6;
endpackage : selfgain_pkg

// [rtl/pin_sync.sv]
// two-flop synchroniser for pins entering the ref_clk domain
`timescale 1ns/1ps
module pin_sync #(
   parameter int           WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta_reg <= INIT;
         sync_reg <= INIT;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;
endmodule : pin_sync

// [rtl/gain_scaler.sv]
// multiplies a corrected result by an unsigned 1.23 scale factor
`timescale 1ns/1ps
module gain_scaler
   import selfgain_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        in_valid,
   input  wire logic [23:0] in_data,
   input  wire logic [23:0] scale,
   output logic             out_valid,
   output logic      [23:0] out_data
);
   logic signed [48:0] product;
   logic signed [25:0] shifted;
   logic        [23:0] sat_value;
   logic               out_valid_reg;
   logic               out_valid_next;
   logic        [23:0] out_data_reg;
   logic        [23:0] out_data_next;

   // ----------------------------------------
   // scaling
   // ----------------------------------------
   // unsigned fixed point
   always_comb begin
      product = 49'($signed(in_data)) * 49'($signed({1'b0, scale}));
      shifted = product[48:FRAC_BITS];
      // scale reaches almost 2x, so clamp instead of wrapping
      if (shifted[25:23] == 3'b000 || shifted[25:23] == 3'b111) begin
         sat_value = shifted[23:0];
      end else if (shifted[25]) begin
         sat_value = 24'h800000;
      end else begin
         sat_value = 24'h7fffff;
      end
   end

   always_comb begin
      out_valid_next = in_valid;
      out_data_next  = out_data_reg;
      if (in_valid) begin
         out_data_next = sat_value;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         out_valid_reg <= 1'b0;
         out_data_reg  <= 24'h000000;
      end else begin
         out_valid_reg <= out_valid_next;
         out_data_reg  <= out_data_next;
      end
   end

   assign out_valid = out_valid_reg;
   assign out_data  = out_data_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_unity_pass: assert property (@(posedge ref_clk) disable iff (rst)
      in_valid && scale == SCALE_UNITY |=> out_data == $past(in_data))
      else $error("unity scale altered the result");
   a_scale_latency: assert property (@(posedge ref_clk) disable iff (rst)
      in_valid |=> out_valid ##1 (out_valid == $past(in_valid)))
      else $error("scaled result not one cycle after input");
endmodule : gain_scaler

// [dv/spi_host_model.sv]
// host-side serial master model for the register port
`timescale 1ns/1ps
module spi_host_model #(
   parameter int HALF = 6
) (
   input  wire logic ref_clk,
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_mosi,
   input  wire logic spi_miso,
   input  wire logic spi_miso_oe
);
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // ----------------------------------------
   // one frame; nbits below 32 aborts it
   // ----------------------------------------
   task automatic xfer(input logic [31:0] frame, input int nbits, output logic [23:0] rdata);
      int i;
      rdata = 24'h000000;
      @(negedge ref_clk);
      spi_cs_n = 1'b0;
      for (i = 0; i < nbits; i++) begin
         spi_mosi = frame[31-i];
         repeat (HALF) @(negedge ref_clk);
         // undriven line must not pass as data
         if (i >= 8) rdata[31-i] = spi_miso_oe ? spi_miso : 1'bx;
         spi_sclk = 1'b1;
         repeat (HALF) @(negedge ref_clk);
         spi_sclk = 1'b0;
      end
      repeat (HALF) @(negedge ref_clk);
      spi_cs_n = 1'b1;
      // released line shows the inverse, not a stale bit
      spi_mosi = ~spi_mosi;
      repeat (8) @(negedge ref_clk);
   endtask : xfer
endmodule : spi_host_model

// [dv/selfgain_threshold_regs_tb.sv]
// self-checking bench for the self-gain and lower-limit bank
`timescale 1ns/1ps
module selfgain_threshold_regs_tb
   import selfgain_pkg::*;
   ;
   logic        ref_clk;
   logic        rst;
   logic        spi_sclk;
   logic        spi_cs_n;
   logic        spi_mosi;
   logic        spi_miso;
   logic        spi_miso_oe;
   logic [2:0]  pga_gain_sel;
   logic [23:0] low_gain_scale;
   logic        corr_valid;
   logic [23:0] corr_result;
   logic        scaled_valid;
   logic [23:0] scaled_result;
   logic        cal_wr_valid;
   logic [2:0]  cal_wr_gain_sel;
   logic [23:0] cal_wr_value;
   logic        ch0_result_valid;
   logic [23:0] ch0_conversion_result;
   logic        unipolar_bipolar_select;
   logic        format_offset_binary;
   logic        ch0_under_range_flag;
   int          fail_count;
   int          check_count;
   logic [23:0] rd;
   logic [6:0]  addrs [6] = '{ADDR_GAIN8, ADDR_GAIN16, ADDR_GAIN32, ADDR_GAIN64,
                              ADDR_GAIN128, ADDR_LIMIT0};
   logic [23:0] pats  [6] = '{24'h123456, 24'ha5c30f, 24'h400000, 24'hffffff,
                              24'h000001, 24'h000010};
   logic [23:0] corrs [3] = '{24'h100000, 24'h7fffff, 24'h800000};
   // {unipolar, offset binary, limit, result, flag}
   logic [50:0] cmp_tab [7] = '{
      {2'h0, 24'h000010, 24'hfffff0, 1'b1}, {2'h2, 24'h000010, 24'hfffff0, 1'b0},
      {2'h1, 24'h000010, 24'hfffff0, 1'b0}, {2'h3, 24'h000010, 24'h00000f, 1'b1},
      {2'h0, 24'hfffff0, 24'hfffff0, 1'b0}, {2'h0, 24'h800000, 24'h7fffff, 1'b0},
      {2'h2, 24'h800000, 24'h7fffff, 1'b1}};

   selfgain_threshold_regs dut (
      .ref_clk(ref_clk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
      .pga_gain_sel(pga_gain_sel), .low_gain_scale(low_gain_scale),
      .corr_valid(corr_valid), .corr_result(corr_result), .scaled_valid(scaled_valid),
      .scaled_result(scaled_result), .cal_wr_valid(cal_wr_valid),
      .cal_wr_gain_sel(cal_wr_gain_sel), .cal_wr_value(cal_wr_value),
      .ch0_result_valid(ch0_result_valid), .ch0_conversion_result(ch0_conversion_result),
      .unipolar_bipolar_select(unipolar_bipolar_select),
      .format_offset_binary(format_offset_binary),
      .ch0_under_range_flag(ch0_under_range_flag));

   spi_host_model host (
      .ref_clk(ref_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

   // ----------------------------------------
   // compare, access and verdict tasks
   // ----------------------------------------
   task automatic check24(input logic [23:0] got, input logic [23:0] want);
      check_count++;
      if (got !== want) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
      end
   endtask : check24

   task automatic check1(input logic got, input logic want);
      check_count++;
      if (got !== want) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
      end
   endtask : check1

   task automatic reg_write(input logic [6:0] a, input logic [23:0] d);
      logic [23:0] dummy;
      host.xfer({1'b0, a, d}, 32, dummy);
   endtask : reg_write

   task automatic reg_read(input logic [6:0] a, input logic [23:0] want);
      logic [23:0] got;
      host.xfer({1'b1, a, 24'h000000}, 32, got);
      check24(got, want);
   endtask : reg_read

   // arithmetic shift truncates as the scaler's product slice does, for every case fed here
   function automatic logic [23:0] exp_scale(input logic [23:0] c, input logic [23:0] s);
      logic signed [48:0] p;
      p = ($signed({{25{c[23]}}, c}) * $signed({25'h0, s})) >>> 23;
      if (p > 49'sh07fffff) return 24'h7fffff;
      if (p < -(49'sh0800000)) return 24'h800000;
      return p[23:0];
   endfunction : exp_scale

   task automatic scale_once(input logic [2:0] g, input logic [23:0] c, input logic [23:0] e);
      pga_gain_sel = g;
      corr_result  = c;
      corr_valid   = 1'b1;
      @(negedge ref_clk);
      corr_valid = 1'b0;
      check1(scaled_valid, 1'b1);
      check24(scaled_result, e);
   endtask : scale_once

   task automatic results();
      if (fail_count == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results

   // ----------------------------------------
   // clock, reset and watchdog
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   initial begin
      // full run is about 14k cycles; allow roughly three and a half times that
      #400us;
      fail_count++;
      results();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      fail_count = 0;
      check_count = 0;
      rst = 1'b1;
      pga_gain_sel = 3'h0;
      low_gain_scale = 24'h400000;
      corr_valid = 1'b0;
      corr_result = 24'h000000;
      cal_wr_valid = 1'b0;
      cal_wr_gain_sel = 3'h0;
      cal_wr_value = 24'h000000;
      ch0_result_valid = 1'b0;
      ch0_conversion_result = 24'h000000;
      unipolar_bipolar_select = 1'b0;
      format_offset_binary = 1'b0;
      repeat (20) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      check1(spi_miso_oe, 1'b0);
      check1(ch0_under_range_flag, 1'b0);
      for (int i = 0; i < 5; i++) reg_read(addrs[i], GAIN_RESET);
      reg_read(ADDR_LIMIT0, LIMIT_RESET);
      for (int i = 0; i < 6; i++) reg_write(addrs[i], pats[i]);
      for (int i = 0; i < 6; i++) reg_read(addrs[i], pats[i]);
      host.xfer({1'b0, ADDR_GAIN8, 24'h777777}, 20, rd);
      reg_read(ADDR_GAIN8, pats[0]);
      reg_write(7'h21, 24'h5a5a5a);
      reg_read(7'h21, 24'h000000);
      reg_read(7'h1a, 24'h000000);
      for (int i = 0; i < 5; i++) begin
         for (int j = 0; j < 3; j++) begin
            scale_once(3'(3 + i), corrs[j], exp_scale(corrs[j], pats[i]));
         end
      end
      scale_once(3'h0, 24'h100000, 24'h080000);
      @(negedge ref_clk);
      check1(scaled_valid, 1'b0);
      cal_wr_gain_sel = 3'h5;
      cal_wr_value = 24'h0abcde;
      cal_wr_valid = 1'b1;
      @(negedge ref_clk);
      cal_wr_gain_sel = 3'h1;
      cal_wr_value = 24'h111111;
      @(negedge ref_clk);
      cal_wr_valid = 1'b0;
      reg_read(ADDR_GAIN32, 24'h0abcde);
      reg_read(ADDR_GAIN8, pats[0]);
      scale_once(3'h5, 24'h100000, exp_scale(24'h100000, 24'h0abcde));
      for (int i = 0; i < 7; i++) begin
         unipolar_bipolar_select = cmp_tab[i][50];
         format_offset_binary = cmp_tab[i][49];
         reg_write(ADDR_LIMIT0, cmp_tab[i][48:25]);
         ch0_conversion_result = cmp_tab[i][24:1];
         ch0_result_valid = 1'b1;
         @(negedge ref_clk);
         ch0_result_valid = 1'b0;
         check1(ch0_under_range_flag, cmp_tab[i][0]);
         ch0_conversion_result = ~cmp_tab[i][24:1];
         repeat (3) @(negedge ref_clk);
         check1(ch0_under_range_flag, cmp_tab[i][0]);
      end
      rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      check1(ch0_under_range_flag, 1'b0);
      reg_read(ADDR_GAIN16, GAIN_RESET);
      // unity word after reset must pass the result through unchanged
      scale_once(3'h4, 24'h100000, 24'h100000);
      reg_read(ADDR_LIMIT0, LIMIT_RESET);
      results();
   end
endmodule : selfgain_threshold_regs_tb
